// ### inc/ahp_defs.vh
// Purpose: Constants for the ADC parallel host port.
// Assumes: Control words are 10 bits wide.
// Notes:   Field positions refer to control register 1.
`ifndef AHP_DEFS_VH
`define AHP_DEFS_VH
`define AHP_CR_W          10
`define AHP_CR0_RST       10'h000
`define AHP_CR1_RST       10'h030
`define AHP_BIT_THR_LO    2
`define AHP_BIT_THR_HI    3
`define AHP_BIT_FORM      4
`define AHP_BIT_POL       5
`define AHP_BIT_COMBINED  6
`define AHP_REG_SEL_BIT   10
`endif

// ### hdl/ahp_fifo.v
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Count output exposes the fill level.
`default_nettype none
module ahp_fifo #(
   parameter WIDTH = 10,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire             i_clk,      // Clock
   input  wire             i_rst,      // Async reset
   input  wire [WIDTH-1:0] i_wdata,    // Write data
   input  wire             i_wvalid,   // Write valid
   output wire             o_wready,   // Not full
   output wire [WIDTH-1:0] o_rdata,    // Head word
   output wire             o_rvalid,   // Not empty
   input  wire             i_rready,   // Pop
   output wire [AW:0]      o_count     // Fill level
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wp_r;
   reg [AW:0]      rp_r;
   wire            push;
   wire            pop;
   assign o_count  = wp_r - rp_r;
   assign o_wready = (o_count != DEPTH[AW:0]) || (DEPTH == 0);
   assign o_rvalid = (o_count != {(AW+1){1'b0}});
   assign push     = i_wvalid && o_wready;
   assign pop      = i_rready && o_rvalid;
   assign o_rdata  = mem[rp_r[AW-1:0]];
   always @(posedge i_clk) begin
      if (push) begin
         mem[wp_r[AW-1:0]] <= i_wdata;
      end
   end
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wp_r <= {(AW+1){1'b0}};
         rp_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ### hdl/ahp_port.v
// Purpose: Parallel host port of a two-input ADC with output FIFO and ready flag.
// Assumes: Host pins are asynchronous; conversion clock is sampled as a pin.
// Notes:   Strobes are formed after a three-stage synchroniser.
// How it works
// - Read strobe: all selects plus read, no write
// - Each read pops one word if the FIFO holds one and drives the bus; a read of an empty FIFO drives zero
// - Write strobe loads control register zero/one
// - Write pin may act as read/not-write
// - Separate mode uses read pin as read
// - Register1 bit6 picks combined; high means read
// - Register1 bit5 sets flag polarity
// - Register1 bit4 picks level or pulse
// - Flag asserts when threshold count reached
// - Level flag drops at first read
// - Recheck only after threshold reads done
// - Pulse lasts half a conversion clock
// - Bits 3:2 select threshold per channels
`include "ahp_defs.vh"
`default_nettype none
module ahp_port #(
   parameter DW    = 10,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire          i_clk,                 // 40 MHz clock
   input  wire          i_rst,                 // Async reset, active high
   input  wire          i_select_a_n,          // Low-active select pin
   input  wire          i_select_b,            // High-active select pin
   input  wire          i_rd_n,                // Read strobe pin, active low
   input  wire          i_wr_n,                // Write or read/not-write pin
   input  wire [DW-1:0] i_data,                // Data bus input
   output reg  [DW-1:0] o_data,                // Data bus output
   output reg           o_data_oe,             // Data bus drive enable
   input  wire          i_conversion_clock_in, // Conversion clock pin
   input  wire          i_two_channels,        // Two channels in use
   input  wire [DW-1:0] i_sample,              // Converted word
   input  wire          i_sample_valid,        // Converted word strobe
   output wire          o_sample_ready,        // FIFO can accept
   output reg           o_fifo_ready_flag,     // Data-available flag
   output reg  [DW-1:0] o_ctrl0,               // Control register 0
   output reg  [DW-1:0] o_ctrl1                // Control register 1
);
   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   reg [2:0] sa_r;
   reg [2:0] sb_r;
   reg [2:0] rd_r;
   reg [2:0] wr_r;
   reg [2:0] cc_r;
   reg       sa_q;
   reg       sb_q;
   reg       rd_q;
   reg       wr_q;
   reg       cc_q;
   reg [DW-1:0] din_a_r;
   reg [DW-1:0] din_b_r;
   reg [DW-1:0] din_c_r;
   reg [DW-1:0] din_q;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sa_r <= 3'h7;
         sb_r <= 3'h0;
         rd_r <= 3'h7;
         wr_r <= 3'h7;
         cc_r <= 3'h0;
         sa_q <= 1'b1;
         sb_q <= 1'b0;
         rd_q <= 1'b1;
         wr_q <= 1'b1;
         cc_q <= 1'b0;
         din_a_r <= {DW{1'b0}};
         din_b_r <= {DW{1'b0}};
         din_c_r <= {DW{1'b0}};
         din_q <= {DW{1'b0}};
      end else begin
         sa_r <= {sa_r[1:0], i_select_a_n};
         sb_r <= {sb_r[1:0], i_select_b};
         rd_r <= {rd_r[1:0], i_rd_n};
         wr_r <= {wr_r[1:0], i_wr_n};
         cc_r <= {cc_r[1:0], i_conversion_clock_in};
         din_a_r <= i_data;
         din_b_r <= din_a_r;
         din_c_r <= din_b_r;
         if (din_b_r == din_c_r) din_q <= din_c_r;
         if (sa_r[1] == sa_r[2]) sa_q <= sa_r[2];
         if (sb_r[1] == sb_r[2]) sb_q <= sb_r[2];
         if (rd_r[1] == rd_r[2]) rd_q <= rd_r[2];
         if (wr_r[1] == wr_r[2]) wr_q <= wr_r[2];
         if (cc_r[1] == cc_r[2]) cc_q <= cc_r[2];
      end
   end

   // -------------------------------------------------------------
   // Strobe formation
   // -------------------------------------------------------------
   wire sel      = !sa_q && sb_q;
   wire combined = o_ctrl1[`AHP_BIT_COMBINED];
   reg  rd_cond;
   reg  wr_cond;
   always @* begin
      if (combined) begin
         rd_cond = sel && wr_q;
         wr_cond = sel && !wr_q;
      end else begin
         rd_cond = sel && !rd_q && wr_q;
         wr_cond = sel && !wr_q && rd_q;
      end
   end
   wire rd_int = rd_cond && !wr_cond;
   wire wr_int = wr_cond && !rd_cond;
   reg  rd_int_r;
   reg  wr_int_r;
   wire rd_start = rd_int && !rd_int_r;
   wire rd_end   = !rd_int && rd_int_r;
   wire wr_end   = !wr_int && wr_int_r;

   // -------------------------------------------------------------
   // FIFO
   // -------------------------------------------------------------
   wire [DW-1:0] f_data;
   wire          f_valid;
   wire [AW:0]   f_count;
   ahp_fifo #(.WIDTH(DW), .DEPTH(DEPTH), .AW(AW)) u_fifo (
      .i_clk    (i_clk),
      .i_rst    (i_rst),
      .i_wdata  (i_sample),
      .i_wvalid (i_sample_valid),
      .o_wready (o_sample_ready),
      .o_rdata  (f_data),
      .o_rvalid (f_valid),
      .i_rready (rd_start),
      .o_count  (f_count)
   );

   // -------------------------------------------------------------
   // Threshold
   // -------------------------------------------------------------
   // threshold table
   function [AW:0] thr_of;
      input [1:0] code;
      input       two;
      begin
         case (code)
            2'h0:    thr_of = two ? 6'h02 : 6'h01;
            2'h1:    thr_of = 6'h04;
            2'h2:    thr_of = 6'h08;
            default: thr_of = two ? 6'h0c : 6'h0e;
         endcase
      end
   endfunction
   wire [AW:0] fifo_threshold =
      thr_of(o_ctrl1[`AHP_BIT_THR_HI:`AHP_BIT_THR_LO], i_two_channels);

   // -------------------------------------------------------------
   // Registers, read data and flag
   // -------------------------------------------------------------
   reg         cc_r2_q;
   reg [DW-1:0] wr_hold_r;
   wire        cc_rise   = cc_q && !cc_r2_q;
   reg         flag_act_r;
   reg         armed_r;
   reg [AW:0]  reads_left_r;
   reg         pulse_r;
   wire        trig      = (f_count >= fifo_threshold);
   wire        pulse_md  = o_ctrl1[`AHP_BIT_FORM];
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rd_int_r     <= 1'b0;
         wr_int_r     <= 1'b0;
         o_ctrl0      <= `AHP_CR0_RST;
         o_ctrl1      <= `AHP_CR1_RST;
         o_data       <= {DW{1'b0}};
         o_data_oe    <= 1'b0;
         cc_r2_q      <= 1'b0;
         flag_act_r   <= 1'b0;
         armed_r      <= 1'b1;
         reads_left_r <= {(AW+1){1'b0}};
         pulse_r      <= 1'b0;
         wr_hold_r    <= {DW{1'b0}};
         o_fifo_ready_flag <= 1'b0;
      end else begin
         rd_int_r <= rd_int;
         wr_int_r <= wr_int;
         cc_r2_q  <= cc_q;
         o_data_oe <= rd_int;
         if (rd_start) begin
            o_data <= f_valid ? f_data : {DW{1'b0}};
         end
         // The host may change the bus as soon as a select drops, clocks
         // before the synchronised strobe ends, so the word is held while
         // the strobe stands and written when it ends.
         // capture on strobe end
         if (wr_int) begin
            wr_hold_r <= din_q;
         end
         if (wr_end) begin
            if (wr_hold_r[`AHP_REG_SEL_BIT-1] == 1'b0) begin
               o_ctrl0 <= wr_hold_r;
            end else begin
               o_ctrl1 <= wr_hold_r;
            end
         end
         if (pulse_md) begin
            flag_act_r <= 1'b0;
            armed_r    <= 1'b1;
            if (cc_rise && trig && !pulse_r) begin
               pulse_r <= 1'b1;
            end else if (!cc_q) begin
               pulse_r <= 1'b0;
            end
         end else begin
            pulse_r <= 1'b0;
            if (armed_r && trig) begin
               flag_act_r   <= 1'b1;
               armed_r      <= 1'b0;
               reads_left_r <= fifo_threshold;
            end else if (!armed_r && rd_start) begin
               flag_act_r <= 1'b0;
            end
            if (!armed_r && rd_end) begin
               if (reads_left_r <= 6'h01) begin
                  armed_r <= 1'b1;
               end
               reads_left_r <= reads_left_r - 1'b1;
            end
         end
         o_fifo_ready_flag <= (pulse_md ? pulse_r : flag_act_r) ~^
                              o_ctrl1[`AHP_BIT_POL];
      end
   end
endmodule
`default_nettype wire

// ### testbench/ahp_port_props.sv
// Purpose: Assertions on the host port pins and control registers.
// Assumes: Pins reach the strobes within about five clocks.
// Notes:   Bound to every port instance.
`default_nettype none
module ahp_port_chk #(
   parameter DW = 10
) (
   input wire logic          i_clk,                 // Clock
   input wire logic          i_rst,                 // Reset
   input wire logic          i_select_a_n,          // Select, low
   input wire logic          i_select_b,            // Select, high
   input wire logic          i_rd_n,                // Read pin
   input wire logic          i_wr_n,                // Write pin
   input wire logic [DW-1:0] i_data,                // Bus in
   input wire logic [DW-1:0] o_data,                // Bus out
   input wire logic          o_data_oe,             // Drive enable
   input wire logic          i_conversion_clock_in, // Conv clock
   input wire logic          i_two_channels,        // Channels
   input wire logic [DW-1:0] i_sample,              // Sample
   input wire logic          i_sample_valid,        // Sample strobe
   input wire logic          o_sample_ready,        // Not full
   input wire logic          o_fifo_ready_flag,     // Flag
   input wire logic [DW-1:0] o_ctrl0,               // Register 0
   input wire logic [DW-1:0] o_ctrl1                // Register 1
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic          sel = !i_select_a_n && i_select_b;
   wire logic          rdc = sel && i_wr_n && (o_ctrl1[6] ? i_rd_n : !i_rd_n);
   wire logic          wrc = sel && !i_wr_n && (o_ctrl1[6] || i_rd_n);
   wire logic          act = o_fifo_ready_flag == o_ctrl1[5];
   logic      [3:0]    age_r;
   logic      [3:0]    run_r;
   logic      [DW-1:0] wd_r;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         age_r <= 4'hf;
         run_r <= 4'h0;
         wd_r  <= '0;
      end else begin
         age_r <= wrc ? 4'h0 : age_r + {3'h0, age_r != 4'hf};
         run_r <= (act && o_ctrl1[4]) ? run_r + 4'h1 : 4'h0;
         if (wrc) wd_r <= i_data;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   chk_oe_from_read: assert property ($rose(o_data_oe) |-> $past(rdc, 2))
      else $error("Drive enable rose without a read");
   chk_oe_released: assert property (!rdc [*7] |-> !o_data_oe)
      else $error("Drive enable outlived the read");
   chk_no_oe_write: assert property (wrc [*6] |-> !o_data_oe)
      else $error("Drive enable during a write");
   chk_ctrl_cause: assert property ($changed(o_ctrl0) || $changed(o_ctrl1) |-> age_r < 4'hc)
      else $error("Control register changed without a write");
   chk_ctrl0_value: assert property ($changed(o_ctrl0) |-> o_ctrl0 == wd_r && !wd_r[9])
      else $error("Register 0 took a wrong value");
   chk_ctrl1_value: assert property ($changed(o_ctrl1) |-> o_ctrl1[8:0] == wd_r[8:0] && wd_r[9])
      else $error("Register 1 took a wrong value");
   chk_pulse_width: assert property (run_r <= 4'h5)
      else $error("Flag pulse too long");
   chk_level_drop: assert property (!o_ctrl1[4] && act && $rose(rdc) |-> ##[1:8] !act)
      else $error("Level flag held over a read");
   cover property ($rose(o_data_oe));
   cover property (run_r == 4'h4);
   cover property ($changed(o_ctrl1));
endmodule
bind ahp_port ahp_port_chk #(.DW(DW)) i_ahp_port_chk (.i_clk(i_clk), .i_rst(i_rst),
   .i_select_a_n(i_select_a_n), .i_select_b(i_select_b), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n),
   .i_data(i_data), .o_data(o_data), .o_data_oe(o_data_oe),
   .i_conversion_clock_in(i_conversion_clock_in), .i_two_channels(i_two_channels),
   .i_sample(i_sample), .i_sample_valid(i_sample_valid), .o_sample_ready(o_sample_ready),
   .o_fifo_ready_flag(o_fifo_ready_flag), .o_ctrl0(o_ctrl0), .o_ctrl1(o_ctrl1));
`default_nettype wire

// ### testbench/ahp_host.sv
// Purpose: Host processor model on the port pins.
// Assumes: Pins change at falling clock edges.
// Notes:   An idle bus shows the inverse of the last word.
`default_nettype none
module ahp_host (
   input  wire logic       i_clk,        // Clock
   input  wire logic [9:0] i_bus,        // Port data out
   input  wire logic       i_oe,         // Port drive enable
   output var  logic       o_select_a_n, // Select, low
   output var  logic       o_select_b,   // Select, high
   output var  logic       o_rd_n,       // Read pin
   output var  logic       o_wr_n,       // Write pin
   output var  logic [9:0] o_data        // Bus to port
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_select_a_n = 1'b1;
      o_select_b = 1'b0;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_data = 10'h000;
   end
   // One cycle; op 0 writes, 1 reads, 2 asserts both strobes when comb is clear and reads when comb is set.
   // direction pin
   task automatic xfer(input logic comb, input logic [1:0] op, input logic [9:0] wd,
                       output logic [9:0] rd);
      @(negedge i_clk);
      o_data = wd;
      o_rd_n = comb || op == 2'd0;
      o_wr_n = comb ? op != 2'd0 : op == 2'd1;
      @(negedge i_clk);
      o_select_a_n = 1'b0;
      o_select_b = 1'b1;
      repeat (8) @(negedge i_clk);
      rd = i_oe ? i_bus : 10'hxxx;
      o_select_a_n = 1'b1;
      o_select_b = 1'b0;
      @(negedge i_clk);
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_data = ~wd;
      repeat (8) @(negedge i_clk);
   endtask
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Purpose: Self-checking bench for the ADC host port.
// Assumes: One channel in use until the last scenario.
// Notes:   Expected values come from the register map.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       i_clk = 1'b0;
   logic       i_rst = 1'b1;
   logic       conv = 1'b0;
   logic       sv = 1'b0;
   logic       two = 1'b0;
   logic [9:0] smp = 10'h000;
   logic [9:0] rdw;
   wire  logic sa_n, sb, rd_n, wr_n, oe, srdy, flag;
   wire  logic [9:0] hd, pd, c0, c1;
   int         failures = 0;
   int         total_checks = 0;
   int         cyc = 0;
   always #12.5 i_clk = ~i_clk;
   always begin
      repeat (4) @(negedge i_clk);
      conv = ~conv;
   end
   ahp_port i_ahp_port (.i_clk(i_clk), .i_rst(i_rst), .i_select_a_n(sa_n), .i_select_b(sb),
      .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data(hd), .o_data(pd), .o_data_oe(oe),
      .i_conversion_clock_in(conv), .i_two_channels(two), .i_sample(smp),
      .i_sample_valid(sv), .o_sample_ready(srdy), .o_fifo_ready_flag(flag),
      .o_ctrl0(c0), .o_ctrl1(c1));
   ahp_host i_ahp_host (.i_clk(i_clk), .i_bus(pd), .i_oe(oe), .o_select_a_n(sa_n),
      .o_select_b(sb), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_data(hd));
   task automatic chk(input logic [9:0] exp, input logic [9:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic push(input logic [9:0] v);
      @(negedge i_clk);
      smp = v;
      sv = 1'b1;
      @(negedge i_clk);
      sv = 1'b0;
   endtask
   task automatic rd_chk(input logic comb, input logic [9:0] exp);
      i_ahp_host.xfer(comb, 2'd1, 10'h000, rdw);
      chk(exp, rdw);
   endtask
   task automatic t_regs;
      chk(10'h030, c1);
      i_ahp_host.xfer(1'b0, 2'd2, 10'h155, rdw);
      chk(10'h000, c0);
      i_ahp_host.xfer(1'b0, 2'd0, 10'h0a5, rdw);
      chk(10'h0a5, c0);
   endtask
   task automatic t_fifo;
      int n;
      for (int i = 0; i < 32; i++) push(10'h100 + 10'(i));
      chk(10'h000, {9'h000, srdy});
      n = 0;
      repeat (16) begin
         @(negedge i_clk);
         n += flag;
      end
      chk(10'h008, 10'(n));
      for (int i = 0; i < 32; i++) rd_chk(1'b0, 10'h100 + 10'(i));
      rd_chk(1'b0, 10'h000);
   endtask
   task automatic t_flag;
      i_ahp_host.xfer(1'b0, 2'd0, 10'h204, rdw);
      chk(10'h004, {1'b0, c1[8:0]});
      chk(10'h001, {9'h000, flag});
      repeat (3) push(10'h022);
      repeat (6) @(negedge i_clk);
      chk(10'h001, {9'h000, flag});
      push(10'h022);
      repeat (6) @(negedge i_clk);
      chk(10'h000, {9'h000, flag});
      rd_chk(1'b0, 10'h022);
      chk(10'h001, {9'h000, flag});
      repeat (3) rd_chk(1'b0, 10'h022);
      repeat (4) push(10'h033);
      repeat (6) @(negedge i_clk);
      chk(10'h000, {9'h000, flag});
   endtask
   task automatic t_comb;
      i_ahp_host.xfer(1'b0, 2'd0, 10'h244, rdw);
      chk(10'h044, {1'b0, c1[8:0]});
      repeat (4) rd_chk(1'b1, 10'h033);
      i_ahp_host.xfer(1'b1, 2'd0, 10'h05a, rdw);
      chk(10'h05a, c0);
   endtask
   task automatic t_two;
      two = 1'b1;
      i_ahp_host.xfer(1'b1, 2'd0, 10'h220, rdw);
      chk(10'h020, {1'b0, c1[8:0]});
      push(10'h0c3);
      repeat (6) @(negedge i_clk);
      chk(10'h000, {9'h000, flag});
      push(10'h0c3);
      repeat (6) @(negedge i_clk);
      chk(10'h001, {9'h000, flag});
      repeat (2) rd_chk(1'b0, 10'h0c3);
      i_ahp_host.xfer(1'b0, 2'd0, 10'h22c, rdw);
      repeat (11) push(10'h0d4);
      repeat (6) @(negedge i_clk);
      chk(10'h000, {9'h000, flag});
      push(10'h0d4);
      repeat (6) @(negedge i_clk);
      chk(10'h001, {9'h000, flag});
   endtask
   task automatic conclude;
      $display("failures=%0d total_checks=%0d", failures, total_checks);
      if (failures == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 4000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      i_rst = 1'b0;
      t_regs();
      t_fifo();
      t_flag();
      t_comb();
      t_two();
      conclude();
   end
endmodule
`default_nettype wire
